// [sim/wpf_host_pm.sv]
// Host power management model counting wake requests
`timescale 1ns/1ps
`default_nettype none
module wpf_host_pm (
	// Clock, reset and event pin
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       power_event_out_n,
	// Wakes seen
	output var  logic [7:0] wake_cnt
);
	logic pe_last_reg;
	// Count edges, not levels: a held event is one wake
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pe_last_reg <= 1'b1;
			wake_cnt    <= 8'h00;
		end else begin
			pe_last_reg <= power_event_out_n;
			if (pe_last_reg && !power_event_out_n)
				wake_cnt <= wake_cnt + 8'h01;
		end
	end
endmodule // wpf_host_pm
`default_nettype wire

// [sim/wpf_top_assertions.sv]
// Concurrent checks on the wake filter ports
`timescale 1ns/1ps
`default_nettype none
`include "wpf_map.vh"
module wpf_top_assert (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic [8:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Receive path
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_sof,
	input wire logic        rx_eof,
	input wire logic        rx_crc_ok,
	input wire logic        rx_ia_match,
	input wire logic        rx_mc_match,
	input wire logic        rx_pattern_match,
	input wire logic        rx_overrun,
	// Pins
	input wire logic        link_up,
	input wire logic        forced_mgmt_offload_pin,
	input wire logic        power_event_out_n,
	input wire logic        clk25_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] cfg_reg;
	logic        pmen_reg;
	// Shadow of the enables, so wake checks know what software asked for
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg  <= 32'h00000000;
			pmen_reg <= 1'b0;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr == `WPF_CFG_OFS)
				cfg_reg <= pwdata;
			if (paddr == `WPF_PM_CONTROL_STATUS_REG_OFS)
				pmen_reg <= pwdata[`WPF_PM_CONTROL_STATUS_REG_EN];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_good_end;
		rx_valid && rx_eof && rx_crc_ok && !rx_overrun;
	endsequence
	sequence s_event_low;
		##[2:4] !power_event_out_n;
	endsequence
	a_access_ready: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_data_idle: assert property (!pready |-> prdata == 32'h00000000)
		else $error("prdata not zero outside access");
	a_unmapped_err: assert property (s_setup ##0 paddr == 9'h1FC |=> pslverr)
		else $error("unmapped read not flagged");
	a_clk_half: assert property (1'b1 |=> clk25_out != $past(clk25_out))
		else $error("clock output not toggling");
	a_event_gated: assert property (!pmen_reg [*2] |-> power_event_out_n)
		else $error("event pin low while disabled");
	a_link_wake: assert property ($changed(link_up) && pmen_reg
		&& cfg_reg[`WPF_CFG_LINK_EN] |-> ##[2:10] !power_event_out_n)
		else $error("link change gave no event");
	a_fixed_wake: assert property (s_good_end ##0 pmen_reg
		&& (rx_ia_match && cfg_reg[`WPF_CFG_IA_EN]
		|| rx_mc_match && cfg_reg[`WPF_CFG_MC_EN]) |-> s_event_low)
		else $error("address match gave no event");
	a_bad_crc_quiet: assert property (rx_valid && rx_eof && !rx_crc_ok
		&& power_event_out_n |=> power_event_out_n [*4])
		else $error("event on bad frame");
endmodule // wpf_top_assert
bind wpf_top wpf_top_assert u_chk (.*);
`default_nettype wire

// [sim/wpf_top_test.sv]
// Self-checking bench for the wake filter block
`timescale 1ns/1ps
`default_nettype none
`include "wpf_map.vh"
module wpf_top_test;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic [8:0]  paddr;
	logic [31:0] pwdata, rd, cfg;
	logic        rx_valid, rx_sof, rx_eof, rx_crc_ok, rx_ia_match;
	logic        rx_mc_match, rx_pattern_match, rx_overrun;
	logic        link_up, forced_mgmt_offload_pin;
	logic [7:0]  rx_data, wake_cnt, e;
	wire  [31:0] prdata;
	wire         pready, pslverr, power_event_out_n, clk25_out;
	int          n_mismatch, samples_checked, ew, pm;
	logic [7:0]  fr[$];
	logic [4:0]  fl[8] = '{5'h08, 5'h18, 5'h18, 5'h00,
		5'h0E, 5'h0E, 5'h09, 5'h09};
	logic [7:0]  cv[8] = '{8'h01, 8'h03, 8'h02, 8'h01,
		8'h10, 8'h08, 8'h20, 8'h00};
	wpf_top DUT (.*);
	wpf_host_pm u_host (.*);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic apb(input logic w, input logic [8:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] x, s);
		samples_checked++;
		if (x !== s) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic mk(input int n, input int s);
		fr = {};
		repeat (n) fr.push_back(8'($urandom));
		fr[12] = 8'h81;
		fr[12 + s] = `WPF_TYPE_HI_VAL;
		fr[13 + s] = `WPF_TYPE_LO_VAL;
		fr[21 + s] = `WPF_OPC_VAL;
		fr[40 + s] = cfg[23:16];
		fr[41 + s] = cfg[31:24];
	endtask
	function automatic logic arp(input int s);
		return fr[12+s] == 8'h08 && fr[13+s] == 8'h06 && fr[21+s] == 8'h01
			&& fr[40+s] == cfg[23:16] && fr[41+s] == cfg[31:24];
	endfunction
	function automatic logic [31:0] sig(input logic [31:0] w);
		logic [31:0] c;
		c = `WPF_CRC_INIT;
		for (int i = 0; i < 32; i++)
			c = (c >> 1) ^ ((c[0] ^ w[i]) ? `WPF_CRC_POLY : 32'h0);
		return c;
	endfunction
	function automatic logic [7:0] model(input logic [4:0] f,
		input logic [31:0] sg);
		logic [7:0] s;
		s = 8'h00;
		if (f[3]) begin
			s[1] = cfg[0] && (arp(0) || cfg[1] && arp(4));
			s[2] = f[1] && cfg[3];
			s[3] = f[2] && cfg[4];
			s[4] = f[0] && !cfg[5];
			s[5] = cfg[6] && !forced_mgmt_offload_pin
				&& sig({fr[3], fr[2], fr[1], fr[0]}) == sg;
		end
		return s;
	endfunction
	task automatic clr;
		apb(1, `WPF_PM_DRIVER_STATUS_REG_OFS, 32'hFF);
		apb(1, `WPF_PM_CONTROL_STATUS_REG_OFS, 32'h8000 | pm);
	endtask
	task automatic frame(input logic [4:0] f, input logic [31:0] sg);
		foreach (fr[i]) begin
			rx_valid <= 1'b1;
			rx_data <= fr[i];
			rx_sof <= (i == 0);
			rx_eof <= (i == fr.size() - 1);
			{rx_crc_ok, rx_ia_match, rx_mc_match, rx_pattern_match} <= f[3:0];
			@(posedge pclk);
		end
		{rx_valid, rx_sof, rx_eof} <= 3'b000;
		repeat (6) @(posedge pclk);
		e = model(f, sg);
		apb(0, `WPF_PM_DRIVER_STATUS_REG_OFS, 0);
		chk("driver status", {24'h0, e}, rd);
		chk("event pin", !(pm && e != 0), power_event_out_n);
		if (pm && e != 0)
			ew++;
		clr();
	endtask
	task automatic test_done;
		$display("checked %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_data, rx_overrun} = '0;
		{rx_valid, rx_sof, rx_eof, rx_crc_ok, rx_ia_match} = '0;
		{rx_mc_match, rx_pattern_match} = '0;
		{link_up, forced_mgmt_offload_pin, presetn} = '0;
		{n_mismatch, samples_checked, ew} = '0;
		void'($urandom(11609));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 12; a += 4) begin
			apb(0, 9'(a), 0);
			chk("reset value", 0, rd);
		end
		apb(0, 9'h1FC, 0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		cfg = $urandom & 32'hFFFF0000;
		for (int i = 0; i < 8; i++) begin
			pm = (i != 4);
			apb(1, `WPF_PM_CONTROL_STATUS_REG_OFS, pm);
			cfg[7:0] = cv[i];
			apb(1, `WPF_CFG_OFS, cfg);
			mk(64, fl[i][4] ? 4 : 0);
			frame(fl[i], 0);
		end
		pm = 1;
		apb(1, `WPF_PM_CONTROL_STATUS_REG_OFS, 1);
		cfg[7:0] = 8'h04;
		apb(1, `WPF_CFG_OFS, cfg);
		for (int k = 0; k < 2; k++) begin
			link_up <= !link_up;
			repeat (12) @(posedge pclk);
			apb(0, `WPF_PM_DRIVER_STATUS_REG_OFS, 0);
			chk("link status", 1, rd);
			chk("link pin", 0, power_event_out_n);
			apb(0, `WPF_STORE_OFS, 0);
			chk("link stored", 0, rd[7]);
			ew++;
			clr();
		end
		cfg[7:0] = 8'h50;
		apb(1, `WPF_CFG_OFS, cfg);
		apb(1, `WPF_SIG_OFS, sig(32'h44332211));
		apb(1, `WPF_SEG_OFS, 32'h800000FF);
		mk(130, 0);
		{fr[3], fr[2], fr[1], fr[0]} = 32'h44332211;
		frame(5'h08, sig(32'h44332211));
		apb(0, `WPF_STORE_OFS, 0);
		chk("stored length", 32'h000000FC, rd);
		apb(0, 9'h178, 0);
		chk("stored tail", {fr[123], fr[122], fr[121], fr[120]}, rd);
		apb(1, `WPF_STORE_OFS, 32'h80);
		forced_mgmt_offload_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		frame(5'h0C, sig(32'h44332211));
		apb(0, `WPF_STORE_OFS, 0);
		chk("offload store", 0, rd[7]);
		forced_mgmt_offload_pin <= 1'b0;
		@(posedge pclk);
		chk("wake count", ew, wake_cnt);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done();
	end
endmodule // wpf_top_test
`default_nettype wire

// [src/wpf_map.vh]
// Register map, field positions, reset values and frame offsets of the wake filter
`ifndef WPF_MAP_VH
`define WPF_MAP_VH

// Register byte offsets
`define WPF_CFG_OFS        9'h000
`define WPF_PM_CONTROL_STATUS_REG_OFS      9'h004
`define WPF_PM_DRIVER_STATUS_REG_OFS       9'h008
`define WPF_STORE_OFS      9'h00C
`define WPF_SIG_OFS        9'h010
`define WPF_SEG_OFS        9'h040
`define WPF_BUF_OFS        9'h100

// Configuration register fields
`define WPF_CFG_RES_EN     0
`define WPF_CFG_VLAN_EN    1
`define WPF_CFG_LINK_EN    2
`define WPF_CFG_MC_EN      3
`define WPF_CFG_IA_EN      4
`define WPF_CFG_PAT_DIS    5
`define WPF_CFG_FLEX_EN    6
`define WPF_CFG_IPLO_LSB   16
`define WPF_CFG_IPHI_LSB   24
`define WPF_CFG_RESET      32'h00000000

// Power control/status fields
`define WPF_PM_CONTROL_STATUS_REG_EN       0
`define WPF_PM_CONTROL_STATUS_REG_STS      15
`define WPF_PM_CONTROL_STATUS_REG_RESET    16'h0000

// Driver status bits
`define WPF_PM_DRIVER_STATUS_REG_LINK      0
`define WPF_PM_DRIVER_STATUS_REG_RES       1
`define WPF_PM_DRIVER_STATUS_REG_MC        2
`define WPF_PM_DRIVER_STATUS_REG_IA        3
`define WPF_PM_DRIVER_STATUS_REG_PAT       4
`define WPF_PM_DRIVER_STATUS_REG_FLEX_LSB  5
`define WPF_PM_DRIVER_STATUS_REG_RESET     8'h00

// Segment register fields
`define WPF_SEG_LMASK_LSB  4
`define WPF_SEG_FIRST_LSB  8
`define WPF_SEG_LAST_LSB   16
`define WPF_SEG_FILT_LSB   24
`define WPF_SEG_ENA        31

// Counts
`define WPF_NUM_SEG        10
`define WPF_NUM_FILT       3
`define WPF_STORE_MAX      7'h7C
`define WPF_BUF_WORDS      31

// Resolution frame offsets and patterns, CRC-32 constants
`define WPF_RES_TYPE_HI    7'h0C
`define WPF_RES_TYPE_LO    7'h0D
`define WPF_RES_OPC        7'h15
`define WPF_RES_IPLO       7'h28
`define WPF_RES_IPHI       7'h29
`define WPF_VLAN_SHIFT     7'h04
`define WPF_TYPE_HI_VAL    8'h08
`define WPF_TYPE_LO_VAL    8'h06
`define WPF_OPC_VAL        8'h01
`define WPF_CRC_INIT       32'hFFFFFFFF
`define WPF_CRC_POLY       32'hEDB88320

`endif

// [src/wpf_top.v]
// Wake-up packet filters, power event output and wake frame storage
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wpf_map.vh"

// Operation
// R1 - VLAN-aware option lets tagged or untagged resolution frames wake; needs resolution enable
// R2 - Link change wake enable lets a link change raise the power event
// R3 - Every wake source is further gated by the event enable bit
// R4 - Resolution wake enable lets a qualifying resolution request raise the event
// R5 - Multicast wake enable lets multicast-filtered frames raise the event
// R6 - Own-address wake enable lets individually addressed frames raise the event
// R7 - IP low byte compared at byte 40, or 44 with VLAN header
// R8 - IP high byte compared at byte 41, or 45 with VLAN header
// R9 - Pattern disable bit blocks wake on wake pattern packets
// R10 - Link going down or up raises the event when enabled
// R11 - Link event flagged in driver status register, no frame stored
// R12 - Three flexible filters, each describing one waking frame format
// R13 - Segments are dword ranges, masks on end dwords, other bytes ignored
// R14 - One CRC signature per filter over its segments; wake on equality
// R15 - Outside logic keeps this clock running and switches it glitch-free
// R16 - Drive a 25 MHz clock usable as substitute source
// R17 - Offload pin disables flexible filters and storage; fixed filters still wake
// R18 - Only first 124 bytes filtered and stored; longer frames accepted
// R19 - Software programs at most ten segments, split four, four, two
// R20 - Wake frame held in registers; bytes past 124 discarded
// R21 - Fixed-filter wake frames also stored and readable after wake
// R22 - Lost frame or inactive flexible filtering wakes without storing
// R23 - Fixed filter wakes only on correct frame CRC
// R24 - Resolution filter needs type 0806 at 12 and opcode 01 at 21
// R25 - Event output is OR of enabled sources gated by event enable
module wpf_top (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire [8:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Receive path after address filtering
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	input  wire        rx_sof,
	input  wire        rx_eof,
	input  wire        rx_crc_ok,
	input  wire        rx_ia_match,
	input  wire        rx_mc_match,
	input  wire        rx_pattern_match,
	input  wire        rx_overrun,
	// Pins
	input  wire        link_up,
	input  wire        forced_mgmt_offload_pin,
	output reg         power_event_out_n,
	output reg         clk25_out
);

	reg  [31:0] cfg_reg;
	reg  [15:0] pm_control_status_reg;
	reg  [7:0]  pm_driver_status_reg;
	reg  [31:0] seg_reg [0:9];
	reg  [31:0] sig_reg [0:2];
	reg  [7:0]  buf_mem [0:123];
	reg  [95:0] crc_reg;
	reg  [6:0]  cnt_reg;
	reg  [6:0]  store_len_reg;
	reg         store_valid_reg;
	reg         plain_ok_reg;
	reg         vlan_ok_reg;
	reg         crc_ok_reg;
	reg         ia_reg;
	reg         mc_reg;
	reg         pat_reg;
	reg         lost_reg;
	reg         done_reg;
	reg  [2:0]  link_sync_reg;
	reg  [2:0]  tco_sync_reg;
	reg         link_reg;
	reg         link_prev_reg;
	reg         tco_reg;
	reg  [31:0] rd_data;
	reg         rd_err;
	reg  [2:0]  flex_byte;
	reg  [2:0]  filt_used;
	reg  [7:0]  ev_set;
	integer     s;
	integer     f;
	// Each process owns its loop variables, so no integer has two drivers
	integer     ef;
	integer     rs;
	integer     rf;
	integer     wf;

	wire [6:0] idx = rx_sof ? 7'h00 : cnt_reg;
	wire       in_win = idx < `WPF_STORE_MAX;
	wire       wr_en = psel & penable & pready & pwrite;
	wire       rd_req = psel & ~penable & ~pwrite;
	wire       plain_base = rx_sof | plain_ok_reg;
	wire       vlan_base = rx_sof | vlan_ok_reg;
	wire [7:0] ip_lo = cfg_reg[`WPF_CFG_IPLO_LSB +: 8];
	wire [7:0] ip_hi = cfg_reg[`WPF_CFG_IPHI_LSB +: 8];
	wire       flex_on = cfg_reg[`WPF_CFG_FLEX_EN] & ~tco_reg;
	wire       any_ev = |ev_set;

	// Byte-wise reflected CRC-32 step
	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0]  d;
		integer      i;
		reg   [31:0] t;
		begin
			t = c ^ {24'h000000, d};
			for (i = 0; i < 8; i = i + 1) begin
				t = t[0] ? ((t >> 1) ^ `WPF_CRC_POLY) : (t >> 1);
			end
			crc_byte = t;
		end
	endfunction

	// Segment covers this byte: dword range plus end masks
	function seg_hit;
		input [31:0] sg;
		input [6:0]  p;
		reg   [4:0]  fd;
		reg   [4:0]  ld;
		begin
			fd = sg[`WPF_SEG_FIRST_LSB +: 5];
			ld = sg[`WPF_SEG_LAST_LSB +: 5];
			seg_hit = sg[`WPF_SEG_ENA] & (p[6:2] >= fd) & (p[6:2] <= ld) &
				((p[6:2] != fd) | sg[p[1:0]]) &
				((p[6:2] != ld) | sg[`WPF_SEG_LMASK_LSB + p[1:0]]); // R13
		end
	endfunction

	// Per-filter byte selection and filter population
	always @* begin
		flex_byte = 3'h0;
		filt_used = 3'h0;
		for (s = 0; s < `WPF_NUM_SEG; s = s + 1) begin
			for (f = 0; f < `WPF_NUM_FILT; f = f + 1) begin
				if (seg_reg[s][`WPF_SEG_FILT_LSB +: 2] == f[1:0]) begin
					filt_used[f] = filt_used[f] | seg_reg[s][`WPF_SEG_ENA];
					if (seg_hit(seg_reg[s], idx)) begin
						flex_byte[f] = 1'b1; // R13
					end
				end
			end
		end
	end

	// Wake sources: frame filters at the end of a frame, link change at any time
	always @* begin
		ev_set = 8'h00;
		if (done_reg) begin
			ev_set[`WPF_PM_DRIVER_STATUS_REG_RES] = cfg_reg[`WPF_CFG_RES_EN] & crc_ok_reg &
				(plain_ok_reg | (cfg_reg[`WPF_CFG_VLAN_EN] & vlan_ok_reg)); // R1 R4 R23
			ev_set[`WPF_PM_DRIVER_STATUS_REG_MC] = cfg_reg[`WPF_CFG_MC_EN] & mc_reg &
				crc_ok_reg; // R5 R23
			ev_set[`WPF_PM_DRIVER_STATUS_REG_IA] = cfg_reg[`WPF_CFG_IA_EN] & ia_reg &
				crc_ok_reg; // R6 R23
			ev_set[`WPF_PM_DRIVER_STATUS_REG_PAT] = ~cfg_reg[`WPF_CFG_PAT_DIS] & pat_reg &
				crc_ok_reg; // R9 R23
			for (ef = 0; ef < `WPF_NUM_FILT; ef = ef + 1) begin
				ev_set[`WPF_PM_DRIVER_STATUS_REG_FLEX_LSB + ef] = flex_on & filt_used[ef] &
					crc_ok_reg &
					(crc_reg[ef*32 +: 32] == sig_reg[ef]); // R12 R14 R17
			end
		end
		ev_set[`WPF_PM_DRIVER_STATUS_REG_LINK] = cfg_reg[`WPF_CFG_LINK_EN] &
			(link_reg != link_prev_reg); // R2 R10
	end

	// Register read decode
	always @* begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			rd_err = 1'b1;
		end else if (paddr >= `WPF_BUF_OFS &&
			paddr < `WPF_BUF_OFS + 9'h07C) begin
			rd_data = {buf_mem[{paddr[6:2], 2'h3}],
				buf_mem[{paddr[6:2], 2'h2}],
				buf_mem[{paddr[6:2], 2'h1}],
				buf_mem[{paddr[6:2], 2'h0}]}; // R21
		end else if (paddr >= `WPF_SEG_OFS &&
			paddr < `WPF_SEG_OFS + 9'h028) begin
			rd_data = seg_reg[paddr[5:2] - 4'h0];
		end else if (paddr >= `WPF_SIG_OFS &&
			paddr < `WPF_SIG_OFS + 9'h00C) begin
			rd_data = sig_reg[paddr[3:2]];
		end else begin
			case (paddr)
			`WPF_CFG_OFS:   rd_data = cfg_reg;
			`WPF_PM_CONTROL_STATUS_REG_OFS: rd_data = {16'h0000, pm_control_status_reg};
			`WPF_PM_DRIVER_STATUS_REG_OFS:  rd_data = {24'h000000, pm_driver_status_reg};
			`WPF_STORE_OFS: rd_data = {24'h000000, store_valid_reg,
				store_len_reg};
			default:        rd_err = 1'b1;
			endcase
		end
	end

	// APB handshake: no wait state, answer registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & rd_err;
			prdata <= rd_req ? rd_data : 32'h00000000;
		end
	end

	// Pin synchronisers; a change counts once stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_sync_reg <= 3'h0;
			tco_sync_reg <= 3'h0;
			link_reg <= 1'b0;
			link_prev_reg <= 1'b0;
			tco_reg <= 1'b0;
		end else begin
			link_sync_reg <= {link_sync_reg[1:0], link_up};
			tco_sync_reg <= {tco_sync_reg[1:0], forced_mgmt_offload_pin};
			if (link_sync_reg[1] == link_sync_reg[2]) begin
				link_reg <= link_sync_reg[2];
			end
			if (tco_sync_reg[1] == tco_sync_reg[2]) begin
				tco_reg <= tco_sync_reg[2];
			end
			link_prev_reg <= link_reg; // R10
		end
	end

	// Substitute clock: half of the 50 MHz bus clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk25_out <= 1'b0;
		end else begin
			clk25_out <= ~clk25_out; // R16
		end
	end

	// Software registers; hardware set wins over a write-one clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `WPF_CFG_RESET;
			pm_control_status_reg <= `WPF_PM_CONTROL_STATUS_REG_RESET;
			pm_driver_status_reg <= `WPF_PM_DRIVER_STATUS_REG_RESET;
			for (rs = 0; rs < `WPF_NUM_SEG; rs = rs + 1) begin
				seg_reg[rs] <= 32'h00000000;
			end
			for (rf = 0; rf < `WPF_NUM_FILT; rf = rf + 1) begin
				sig_reg[rf] <= 32'h00000000;
			end
		end else begin
			if (wr_en && paddr == `WPF_CFG_OFS) begin
				cfg_reg <= pwdata;
			end
			if (wr_en && paddr >= `WPF_SEG_OFS &&
				paddr < `WPF_SEG_OFS + 9'h028) begin
				seg_reg[paddr[5:2]] <= pwdata; // R19
			end
			if (wr_en && paddr >= `WPF_SIG_OFS &&
				paddr < `WPF_SIG_OFS + 9'h00C) begin
				sig_reg[paddr[3:2]] <= pwdata;
			end
			if (wr_en && paddr == `WPF_PM_CONTROL_STATUS_REG_OFS) begin
				pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_EN] <= pwdata[`WPF_PM_CONTROL_STATUS_REG_EN];
				pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_STS] <=
					(pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_STS] &
					~pwdata[`WPF_PM_CONTROL_STATUS_REG_STS]) | any_ev; // R25
			end else if (any_ev) begin
				pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_STS] <= 1'b1; // R25
			end
			if (wr_en && paddr == `WPF_PM_DRIVER_STATUS_REG_OFS) begin
				pm_driver_status_reg <= (pm_driver_status_reg &
					~pwdata[7:0]) | ev_set; // R11
			end else begin
				pm_driver_status_reg <= pm_driver_status_reg | ev_set; // R11
			end
		end
	end

	// Event pin: pending status gated by the event enable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_event_out_n <= 1'b1;
		end else begin
			power_event_out_n <= ~(pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_STS] &
				pm_control_status_reg[`WPF_PM_CONTROL_STATUS_REG_EN]); // R3 R25
		end
	end

	// Frame walk: byte count, resolution match, signatures, end flags
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 7'h00;
			plain_ok_reg <= 1'b0;
			vlan_ok_reg <= 1'b0;
			crc_reg <= {3{`WPF_CRC_INIT}};
			crc_ok_reg <= 1'b0;
			ia_reg <= 1'b0;
			mc_reg <= 1'b0;
			pat_reg <= 1'b0;
			lost_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= rx_valid & rx_eof;
			if (rx_valid) begin
				// Count saturates; longer frames pass but are not looked at
				cnt_reg <= in_win ? idx + 7'h01 : `WPF_STORE_MAX; // R18
				plain_ok_reg <= plain_base & ~(in_win & (
					(idx == `WPF_RES_TYPE_HI && rx_data != `WPF_TYPE_HI_VAL) ||
					(idx == `WPF_RES_TYPE_LO && rx_data != `WPF_TYPE_LO_VAL) ||
					(idx == `WPF_RES_OPC && rx_data != `WPF_OPC_VAL) ||
					(idx == `WPF_RES_IPLO && rx_data != ip_lo) ||
					(idx == `WPF_RES_IPHI && rx_data != ip_hi))); // R7 R8 R24
				vlan_ok_reg <= vlan_base & ~(in_win & (
					(idx == `WPF_RES_TYPE_HI + `WPF_VLAN_SHIFT &&
						rx_data != `WPF_TYPE_HI_VAL) ||
					(idx == `WPF_RES_TYPE_LO + `WPF_VLAN_SHIFT &&
						rx_data != `WPF_TYPE_LO_VAL) ||
					(idx == `WPF_RES_OPC + `WPF_VLAN_SHIFT &&
						rx_data != `WPF_OPC_VAL) ||
					(idx == `WPF_RES_IPLO + `WPF_VLAN_SHIFT &&
						rx_data != ip_lo) ||
					(idx == `WPF_RES_IPHI + `WPF_VLAN_SHIFT &&
						rx_data != ip_hi))); // R1 R7 R8
				for (wf = 0; wf < `WPF_NUM_FILT; wf = wf + 1) begin
					if (in_win && flex_byte[wf]) begin
						crc_reg[wf*32 +: 32] <= crc_byte(rx_sof ?
							`WPF_CRC_INIT :
							crc_reg[wf*32 +: 32], rx_data); // R14 R18
					end else if (rx_sof) begin
						crc_reg[wf*32 +: 32] <= `WPF_CRC_INIT;
					end
				end
				lost_reg <= (~rx_sof & lost_reg) | rx_overrun; // R22
				if (rx_eof) begin
					crc_ok_reg <= rx_crc_ok;
					ia_reg <= rx_ia_match;
					mc_reg <= rx_mc_match;
					pat_reg <= rx_pattern_match;
				end
			end
		end
	end

	// Frame storage; a held frame is kept until software drops the valid bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_valid_reg <= 1'b0;
			store_len_reg <= 7'h00;
		end else begin
			if (done_reg && !store_valid_reg && !lost_reg && flex_on &&
				(|ev_set[7:1])) begin
				store_valid_reg <= 1'b1; // R11 R17 R21 R22
				store_len_reg <= cnt_reg; // R20
			end else if (wr_en && paddr == `WPF_STORE_OFS &&
				pwdata[7]) begin
				store_valid_reg <= 1'b0;
			end
		end
	end

	// Buffer bytes carry no reset; only the first 124 are written
	always @(posedge pclk) begin
		if (rx_valid && in_win && !store_valid_reg && flex_on) begin
			buf_mem[idx] <= rx_data; // R20
		end
	end

endmodule // wpf_top

`default_nettype wire
